// ==== rtl/fld_consts.svh ====
// constants of the flash driver register port and its bus master
`ifndef FLD_CONSTS_SVH
`define FLD_CONSTS_SVH
`define FLD_DEV_ADDR     7'h64
`define FLD_REG_MODE     8'h01
`define FLD_REG_CFG      8'h02
`define FLD_REG_FLASH    8'h03
`define FLD_REG_TORCH    8'h04
`define FLD_REG_FAULT    8'h05
`define FLD_REG_IDRST    8'h06
`define FLD_RST_MODE     8'h20
`define FLD_RST_CFG      8'h19
`define FLD_RST_FLASH    8'h00
`define FLD_RST_TORCH    8'h00
`define FLD_RST_FAULT    8'h00
`define FLD_SRST_BIT     7
`define FLD_FAULT_MASK   8'h67
`define FLD_CLK_HZ       10000000
`define FLD_SCL_HZ       100000
`define FLD_QTR_CYC      ((`FLD_CLK_HZ + 4 * `FLD_SCL_HZ - 1) / (4 * `FLD_SCL_HZ))
`define FLD_AV_CMD       4'h0
`define FLD_AV_STAT      4'h4
`define FLD_CMD_OP_LSB   8
`define FLD_CMD_OP_MSB   10
`define FLD_CMD_NACK     11
`define FLD_ST_BUSY      0
`define FLD_ST_NACK      1
`define FLD_ST_XFER      2
`define FLD_ST_RX_LSB    8
`endif

// ==== rtl/fld_pkg.sv ====
// types of the flash driver register port and its bus master
package fld_pkg;
    typedef enum logic [2:0] {op_none, op_start, op_stop, op_write, op_read} fld_op_t;
    typedef enum {s_idle, s_addr, s_ack_a, s_reg, s_ack_r, s_wdata, s_ack_w, s_rdata, s_mack} fld_sst_t;
    typedef enum {m_idle, m_start, m_stop, m_bit} fld_mst_t;
endpackage

// ==== rtl/fld_i2c_if.sv ====
// two-wire link between the bus master and the register port
`timescale 1ns/100ps
interface fld_i2c_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    // open drain with pull-up: any enabled low output wins
    wire  scl = ~(scl_oe & ~scl_o);
    wire  sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
    modport host (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
    modport dev (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// ==== rtl/fld_line_sync.sv ====
// two-stage synchroniser for scl and sda with one extra stage for edges
`timescale 1ns/100ps
module fld_line_sync (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_s,
    output logic      sda_s,
    output logic      scl_p,
    output logic      sda_p
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] prev_q;

    // idle bus is high, so all stages reset high
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= 2'h3;
            sync_q <= 2'h3;
            prev_q <= 2'h3;
        end else begin
            meta_q <= {scl_in, sda_in};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign scl_s = sync_q[1];
    assign sda_s = sync_q[0];
    assign scl_p = prev_q[1];
    assign sda_p = prev_q[0];
endmodule // fld_line_sync

// ==== rtl/fld_i2c_slave.sv ====
// register port of the flash led driver: two-wire slave and its six registers
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps
`include "fld_consts.svh"
// Notes on behaviour
// - slave only, up to 400 kHz clock
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - sda changes only while scl low
// - bytes followed by ninth acknowledge clock
// - acknowledger holds sda low through high
// - answer only bus address 1100100
// - acknowledge address byte only on match
// - write: address, register pointer, data, msb first
// - store data, pointer advances after each acknowledge
// - read: write pointer, repeated start, read
// - read shifts register, advances on master acknowledge
// - master not-acknowledge releases sda
// - no limit on bytes per transfer
// - master starts only on idle bus
// - defaults on power-on and software reset
// - defaults 20, 19, 00, 00, 00
// - bit 7 of 06 resets, self-clears
// - fault flags set by events, read clears
// - reserved bits written zero, ignored; the register file stores them as written
module fld_i2c_slave #(
    parameter logic [2:0] DEV_ID  = 3'h5, // arbitrary value
    parameter logic [2:0] DEV_REV = 3'h0  // arbitrary value
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    fld_i2c_if.dev          bus,
    input  wire logic [7:0] fault_event,
    output logic [7:0]      mode_enable,
    output logic [7:0]      timing_configuration,
    output logic [7:0]      flash_current_level,
    output logic [7:0]      torch_current_level,
    output logic [7:0]      fault_flags
);
    // ***********************************************
    // line sampling and bus conditions
    // ***********************************************
    logic             scl_s;
    logic             sda_s;
    logic             scl_p;
    logic             sda_p;
    fld_pkg::fld_sst_t st_q;
    logic [3:0]       cnt_q;
    logic [7:0]       sh_q;
    logic [7:0]       ptr_q;
    logic             rw_q;
    logic             oe_q;
    logic             mack_q;
    logic [7:0]       mode_q;
    logic [7:0]       cfg_q;
    logic [7:0]       flash_q;
    logic [7:0]       torch_q;
    logic [7:0]       fault_q;

    // 10 MHz sampling gives 25 samples per bit at 400 kHz
    fld_line_sync u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .scl_in  (bus.scl),
        .sda_in  (bus.sda),
        .scl_s   (scl_s),
        .sda_s   (sda_s),
        .scl_p   (scl_p),
        .sda_p   (sda_p)
    );

    wire logic start_c  = scl_s & scl_p & sda_p & ~sda_s;
    wire logic stop_c   = scl_s & scl_p & ~sda_p & sda_s;
    wire logic scl_rise = scl_s & ~scl_p;
    wire logic scl_fall = ~scl_s & scl_p;
    wire logic byte_end = scl_fall & (cnt_q == 4'h8);
    wire logic addr_hit = (sh_q[7:1] == `FLD_DEV_ADDR);

    // ***********************************************
    // register decode
    // ***********************************************
    function automatic logic [7:0] rd_reg(input logic [7:0] a);
        case (a)
            `FLD_REG_MODE:  rd_reg = mode_q;
            `FLD_REG_CFG:   rd_reg = cfg_q;
            `FLD_REG_FLASH: rd_reg = flash_q;
            `FLD_REG_TORCH: rd_reg = torch_q;
            `FLD_REG_FAULT: rd_reg = fault_q;
            `FLD_REG_IDRST: rd_reg = {2'h0, DEV_ID, DEV_REV};
            default:        rd_reg = 8'h00;
        endcase
    endfunction

    wire logic       ld_first = (st_q == fld_pkg::s_ack_a) & scl_fall & rw_q;
    wire logic       ld_next  = (st_q == fld_pkg::s_mack) & scl_fall & mack_q;
    wire logic       ld_stb   = ld_first | ld_next;
    wire logic [7:0] ld_addr  = ld_first ? ptr_q : ptr_q + 8'h01;
    wire logic [7:0] ld_val   = rd_reg(ld_addr);
    // a flag counts as read once its byte is loaded for shifting
    wire logic       flt_clr  = ld_stb & (ld_addr == `FLD_REG_FAULT);
    wire logic       wr_stb   = (st_q == fld_pkg::s_wdata) & byte_end & ~start_c & ~stop_c;
    wire logic       srst     = wr_stb & (ptr_q == `FLD_REG_IDRST) & sh_q[`FLD_SRST_BIT];

    // ***********************************************
    // protocol engine
    // ***********************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_q   <= fld_pkg::s_idle;
            cnt_q  <= 4'h0;
            sh_q   <= 8'h00;
            ptr_q  <= 8'h00;
            rw_q   <= 1'b0;
            oe_q   <= 1'b0;
            mack_q <= 1'b0;
        end else if (start_c) begin
            st_q  <= fld_pkg::s_addr;
            cnt_q <= 4'h0;
            oe_q  <= 1'b0;
        end else if (stop_c) begin
            st_q <= fld_pkg::s_idle;
            oe_q <= 1'b0;
        end else begin
            case (st_q)
                fld_pkg::s_addr, fld_pkg::s_reg, fld_pkg::s_wdata: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_end) begin
                        cnt_q <= 4'h0;
                        oe_q  <= 1'b1;
                        case (st_q)
                            fld_pkg::s_addr: begin
                                rw_q <= sh_q[0];
                                if (addr_hit) begin
                                    st_q <= fld_pkg::s_ack_a;
                                end else begin
                                    st_q <= fld_pkg::s_idle;
                                    oe_q <= 1'b0;
                                end
                            end
                            fld_pkg::s_reg: begin
                                ptr_q <= sh_q;
                                st_q  <= fld_pkg::s_ack_r;
                            end
                            default: st_q <= fld_pkg::s_ack_w;
                        endcase
                    end
                end
                fld_pkg::s_ack_a: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            sh_q <= ld_val;
                            oe_q <= ~ld_val[7];
                            st_q <= fld_pkg::s_rdata;
                        end else begin
                            oe_q <= 1'b0;
                            st_q <= fld_pkg::s_reg;
                        end
                    end
                end
                fld_pkg::s_ack_r: begin
                    if (scl_fall) begin
                        oe_q <= 1'b0;
                        st_q <= fld_pkg::s_wdata;
                    end
                end
                fld_pkg::s_ack_w: begin
                    if (scl_fall) begin
                        oe_q  <= 1'b0;
                        ptr_q <= ptr_q + 8'h01;
                        st_q  <= fld_pkg::s_wdata;
                    end
                end
                fld_pkg::s_rdata: begin
                    // drive only after scl is seen low, so data never moves in a high phase
                    if (scl_fall) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h7) begin
                            oe_q <= 1'b0;
                            st_q <= fld_pkg::s_mack;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            oe_q <= ~sh_q[6];
                        end
                    end
                end
                fld_pkg::s_mack: begin
                    if (scl_rise) begin
                        mack_q <= ~sda_s;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            ptr_q <= ptr_q + 8'h01;
                            sh_q  <= ld_val;
                            oe_q  <= ~ld_val[7];
                            cnt_q <= 4'h0;
                            st_q  <= fld_pkg::s_rdata;
                        end else begin
                            st_q <= fld_pkg::s_idle;
                        end
                    end
                end
                default: st_q <= fld_pkg::s_idle;
            endcase
        end
    end

    // ***********************************************
    // register file
    // ***********************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q  <= `FLD_RST_MODE;
            cfg_q   <= `FLD_RST_CFG;
            flash_q <= `FLD_RST_FLASH;
            torch_q <= `FLD_RST_TORCH;
        end else if (srst) begin
            mode_q  <= `FLD_RST_MODE;
            cfg_q   <= `FLD_RST_CFG;
            flash_q <= `FLD_RST_FLASH;
            torch_q <= `FLD_RST_TORCH;
        end else if (wr_stb) begin
            // reserved bits are stored as written; 0x05, 0x06 and unmapped take nothing
            case (ptr_q)
                `FLD_REG_MODE:  mode_q  <= sh_q;
                `FLD_REG_CFG:   cfg_q   <= sh_q;
                `FLD_REG_FLASH: flash_q <= sh_q;
                `FLD_REG_TORCH: torch_q <= sh_q;
                default:        mode_q  <= mode_q;
            endcase
        end
    end

    // a new event wins over a read clear in the same cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fault_q <= `FLD_RST_FAULT;
        end else if (srst) begin
            fault_q <= `FLD_RST_FAULT;
        end else begin
            fault_q <= (fault_q & ~{8{flt_clr}}) | (fault_event & `FLD_FAULT_MASK);
        end
    end

    assign bus.sda_s_o          = 1'b0;
    assign bus.sda_s_oe         = oe_q;
    assign mode_enable          = mode_q;
    assign timing_configuration = cfg_q;
    assign flash_current_level  = flash_q;
    assign torch_current_level  = torch_q;
    assign fault_flags          = fault_q;
endmodule // fld_i2c_slave

// ==== rtl/fld_i2c_master.sv ====
// two-wire bus master driven by software over avalon-mm
`timescale 1ns/100ps
`include "fld_consts.svh"
module fld_i2c_master (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    fld_i2c_if.host          bus,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    // ***********************************************
    // bus sampling and avalon decode
    // ***********************************************
    logic             scl_s;
    logic             sda_s;
    fld_pkg::fld_mst_t st_q;
    logic [1:0]       ph_q;
    logic [7:0]       tq_q;
    logic [3:0]       bi_q;
    logic             scl_oe_q;
    logic             sda_oe_q;
    logic [7:0]       tx_q;
    logic [7:0]       rx_q;
    logic             rd_op_q;
    logic             nack_cmd_q;
    logic             nack_q;
    logic             xfer_q;
    logic             rd_done_q;
    logic [31:0]      rdata_q;

    fld_line_sync u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .scl_in  (bus.scl),
        .sda_in  (bus.sda),
        .scl_s   (scl_s),
        .sda_s   (sda_s),
        .scl_p   (),
        .sda_p   ()
    );

    wire logic            busy    = (st_q != fld_pkg::m_idle);
    wire logic            cmd_sel = avs_write & (avs_address == `FLD_AV_CMD);
    wire logic            cmd_go  = cmd_sel & ~busy;
    wire fld_pkg::fld_op_t op     = fld_pkg::fld_op_t'(avs_writedata[`FLD_CMD_OP_MSB:`FLD_CMD_OP_LSB]);
    // stall a command until the previous one is done
    assign avs_waitrequest = (cmd_sel & busy) | (avs_read & ~rd_done_q);

    wire logic tick  = (tq_q == 8'(`FLD_QTR_CYC - 1));
    // a first start waits for both lines high
    wire logic hold  = (st_q == fld_pkg::m_start) & (ph_q == 2'h0) & ~xfer_q & ~(scl_s & sda_s);
    wire logic drv   = rd_op_q ? ((bi_q == 4'h8) & ~nack_cmd_q) : ((bi_q != 4'h8) & ~tx_q[7]);

    // ***********************************************
    // bit engine, four quarters per scl period
    // ***********************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_q       <= fld_pkg::m_idle;
            ph_q       <= 2'h0;
            tq_q       <= 8'h00;
            bi_q       <= 4'h0;
            scl_oe_q   <= 1'b0;
            sda_oe_q   <= 1'b0;
            tx_q       <= 8'h00;
            rx_q       <= 8'h00;
            rd_op_q    <= 1'b0;
            nack_cmd_q <= 1'b0;
            nack_q     <= 1'b0;
            xfer_q     <= 1'b0;
        end else if (st_q == fld_pkg::m_idle) begin
            tq_q <= 8'h00;
            ph_q <= 2'h0;
            bi_q <= 4'h0;
            if (cmd_go) begin
                tx_q       <= avs_writedata[7:0];
                rd_op_q    <= (op == fld_pkg::op_read);
                nack_cmd_q <= avs_writedata[`FLD_CMD_NACK];
                case (op)
                    fld_pkg::op_start: begin
                        st_q     <= fld_pkg::m_start;
                        sda_oe_q <= 1'b0;
                    end
                    fld_pkg::op_stop:  st_q <= fld_pkg::m_stop;
                    fld_pkg::op_write: st_q <= fld_pkg::m_bit;
                    fld_pkg::op_read:  st_q <= fld_pkg::m_bit;
                    default:           st_q <= fld_pkg::m_idle;
                endcase
            end
        end else begin
            tq_q <= (tick || hold) ? 8'h00 : tq_q + 8'h01;
            if (tick) begin
                ph_q <= ph_q + 2'h1;
                case (st_q)
                    fld_pkg::m_start: begin
                        case (ph_q)
                            2'h0:    scl_oe_q <= 1'b0;
                            2'h1:    sda_oe_q <= 1'b1;
                            2'h2:    scl_oe_q <= 1'b1;
                            default: begin
                                st_q   <= fld_pkg::m_idle;
                                xfer_q <= 1'b1;
                            end
                        endcase
                    end
                    fld_pkg::m_stop: begin
                        case (ph_q)
                            2'h0:    sda_oe_q <= 1'b1;
                            2'h1:    scl_oe_q <= 1'b0;
                            2'h2:    sda_oe_q <= 1'b0;
                            default: begin
                                st_q   <= fld_pkg::m_idle;
                                xfer_q <= 1'b0;
                            end
                        endcase
                    end
                    default: begin
                        case (ph_q)
                            // data moves a quarter after scl falls, never with it
                            2'h0:    sda_oe_q <= drv;
                            2'h1:    scl_oe_q <= 1'b0;
                            2'h2: begin
                                if (bi_q == 4'h8 && !rd_op_q) begin
                                    nack_q <= sda_s;
                                end
                                if (bi_q != 4'h8 && rd_op_q) begin
                                    rx_q <= {rx_q[6:0], sda_s};
                                end
                            end
                            default: begin
                                scl_oe_q <= 1'b1;
                                tx_q     <= {tx_q[6:0], 1'b0};
                                bi_q     <= bi_q + 4'h1;
                                if (bi_q == 4'h8) begin
                                    st_q <= fld_pkg::m_idle;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    // ***********************************************
    // status readback, one wait cycle per read
    // ***********************************************
    wire logic [31:0] stat_w = {16'h0000, rx_q, 5'h00, xfer_q, nack_q, busy};

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_done_q <= 1'b0;
            rdata_q   <= 32'h00000000;
        end else begin
            rd_done_q <= avs_read & ~rd_done_q;
            rdata_q   <= (avs_address == `FLD_AV_STAT) ? stat_w : 32'h00000000;
        end
    end

    assign avs_readdata = rdata_q;
    assign bus.scl_o    = 1'b0;
    assign bus.scl_oe   = scl_oe_q;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = sda_oe_q;
endmodule // fld_i2c_master

// ==== testbench/fld_checker.sv ====
// assertions on the two-wire link between the bus master and the register port
`timescale 1ns/100ps
module fld_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_oe
);
    // ****************
    // link trackers
    // ****************
    logic       scl_q, sda_q, first_q, act_q, rd_q, xfer_q, nack_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    wire        rise = scl & ~scl_q;
    wire        st   = scl & scl_q & sda_q & ~sda;
    wire        sp   = scl & scl_q & ~sda_q & sda;
    wire        ack  = rise & (bit_q == 4'h8);
    wire        hit  = sh_q[7:1] == 7'h64;
    wire        rnak = ack & ~first_q & act_q & rd_q & sda;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            {scl_q, sda_q, first_q, act_q, rd_q, xfer_q, nack_q, bit_q, sh_q} <= {2'b11, 17'h0};
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            xfer_q <= st | (xfer_q & ~sp);
            first_q <= st | (first_q & ~ack);
            nack_q <= ~(st | sp) & (nack_q | rnak);
            bit_q <= st ? 4'h0 : (rise ? (ack ? 4'h0 : bit_q + 4'h1) : bit_q);
            if (rise) sh_q <= {sh_q[6:0], sda};
            // direction and match latched once per address byte
            if (ack & first_q) {act_q, rd_q} <= {hit, sh_q[0]};
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence oe_held;
        $stable(sda_s_oe) [*8];
    endsequence
    chg_low_a: assert property ($changed(sda_s_oe) |-> !scl) else $error("slave data moved in clock high");
    hold_hi_a: assert property ($rose(scl) |=> oe_held) else $error("slave data unstable in clock high");
    hi_len_a: assert property ($rose(scl) |-> scl [*8]) else $error("clock high phase too short");
    addr_ack_a: assert property (ack && first_q && hit |-> !sda) else $error("own address not acked");
    addr_nak_a: assert property (ack && first_q && !hit |-> sda && !sda_s_oe) else $error("foreign acked");
    wr_ack_a: assert property (ack && !first_q && act_q && !rd_q |-> !sda) else $error("write not acked");
    nak_rel_a: assert property (nack_q |-> !sda_s_oe) else $error("data held after not-ack");
    idle_rel_a: assert property (!xfer_q |-> !sda_s_oe) else $error("data driven on idle bus");
endmodule // fld_checker

// ==== testbench/tb_top.sv ====
// self-checking bench: avalon master end and register port joined by the link
`timescale 1ns/100ps
`include "fld_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic        clock, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, st;
    logic [7:0]  fault_event, mode_enable, timing_configuration, flash_current_level, torch_current_level, fault_flags;
    wire  [39:0] regs = {mode_enable, timing_configuration, flash_current_level, torch_current_level, fault_flags};
    int          err_total = 0;
    int          n_checks = 0;
    fld_i2c_if fld_i2c_if_i ();
    fld_i2c_master fld_i2c_master_i (.clock(clock), .sys_rst(sys_rst), .bus(fld_i2c_if_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    fld_i2c_slave fld_i2c_slave_i (.clock(clock), .sys_rst(sys_rst), .bus(fld_i2c_if_i), .fault_event(fault_event),
        .mode_enable(mode_enable), .timing_configuration(timing_configuration),
        .flash_current_level(flash_current_level), .torch_current_level(torch_current_level),
        .fault_flags(fault_flags));
    fld_checker fld_checker_i (.clock(clock), .sys_rst(sys_rst), .scl(fld_i2c_if_i.scl), .sda(fld_i2c_if_i.sda),
        .sda_s_oe(fld_i2c_if_i.sda_s_oe));
    // ****************
    // access tasks
    // ****************
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // each task lets one edge pass first so no strobe is set twice in a step
    task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic op(input logic [2:0] o, input logic [7:0] b, input logic nk);
        av_wr(`FLD_AV_CMD, {20'h0, nk, o, b});
        do av_rd(`FLD_AV_STAT, st); while (st[`FLD_ST_BUSY] !== 1'b0);
    endtask
    task automatic wb(input logic [7:0] b, input logic nak);
        op(3'h3, b, 1'b0);
        `CHK(st[`FLD_ST_NACK], nak)
    endtask
    task automatic wregs(input logic [7:0] p, input logic [7:0] d[$]);
        op(3'h1, 8'h00, 1'b0);
        wb(8'hc8, 1'b0);
        wb(p, 1'b0);
        foreach (d[i]) wb(d[i], 1'b0);
        op(3'h2, 8'h00, 1'b0);
    endtask
    task automatic rregs(input logic [7:0] p, input logic [7:0] e[$]);
        op(3'h1, 8'h00, 1'b0);
        wb(8'hc8, 1'b0);
        wb(p, 1'b0);
        op(3'h1, 8'h00, 1'b0);
        wb(8'hc9, 1'b0);
        foreach (e[i]) begin
            op(3'h4, 8'h00, i == e.size() - 1);
            `CHK(st[15:8], e[i])
        end
        op(3'h2, 8'h00, 1'b0);
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        repeat (80000) @(posedge clock);
        err_total++;
        final_report();
    end
    initial begin
        sys_rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata, fault_event} = '0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        `CHK(regs, 40'h2019000000)
        rregs(8'h00, '{8'h00, 8'h20, 8'h19, 8'h00, 8'h00, 8'h00, 8'h28, 8'h00});
        // reserved bits stay zero in every written byte
        wregs(8'h01, '{8'h15, 8'h3c, 8'h7f, 8'h11, 8'h67, 8'h38, 8'h99});
        `CHK(regs, 40'h153c7f1100)
        rregs(8'h03, '{8'h7f, 8'h11});
        // one bit off the own address: later bytes must go unanswered
        op(3'h1, 8'h00, 1'b0);
        wb(8'hca, 1'b1);
        wb(8'h01, 1'b1);
        wb(8'h00, 1'b1);
        op(3'h2, 8'h00, 1'b0);
        `CHK(regs, 40'h153c7f1100)
        fault_event <= 8'hff;
        @(posedge clock);
        fault_event <= 8'h00;
        repeat (2) @(posedge clock);
        `CHK(fault_flags, 8'h67)
        rregs(8'h05, '{8'h67, 8'h28});
        `CHK(fault_flags, 8'h00)
        fault_event <= 8'h21;
        @(posedge clock);
        fault_event <= 8'h00;
        wregs(8'h06, '{8'h80});
        `CHK(regs, 40'h2019000000)
        rregs(8'h06, '{8'h28});
        final_report();
    end
endmodule // tb_top
